// >>> core/uart_host_pkg.sv
// Purpose: Shared constants for the serial-unit host controller
// Assumes: Device registers are byte wide and sit behind an 8-bit address port
// Notes: Host-side register offsets and device offsets are named here once
package uart_host_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int DEV_W = 8;
   localparam int CNT_W = 8;

   // Device register offsets on the device port
   localparam logic [7:0] DEV_SERIAL_MODE_OFS = 8'h00; // serial_mode_register
   localparam logic [7:0] DEV_BREAK_CTL_OFS = 8'h01;
   localparam logic [7:0] DEV_TX_STATUS_OFS = 8'h02; // transmit_status_register
   localparam logic [7:0] DEV_TX_BUFFER_OFS = 8'h03; // transmit_buffer_register

   // Fields of serial_mode_register
   localparam int UNIT_POWER_ENABLE_POS = 7;
   localparam int TRANSMIT_ENABLE_BIT_POS = 6;
   localparam int RECEIVE_ENABLE_BIT_POS = 5;
   localparam int PARITY_SELECT_LOW_POS = 3; // parity_select_high at +1
   // Fields of the break control register
   localparam int BREAK_TRANSMIT_TRIGGER_POS = 5;
   localparam int BREAK_LENGTH_LOW_POS = 2; // break_length_bit2..bit0
   localparam logic [2:0] BREAK_LENGTH_LEGACY = 3'h5;
   localparam logic [1:0] PARITY_NONE = 2'h0;
   // Fields of transmit_status_register
   localparam int TX_BUFFER_FULL_FLAG_POS = 1;
   localparam int TX_SHIFT_ACTIVE_FLAG_POS = 0;

   // Host register offsets
   localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
   localparam logic [7:0] HOST_STATUS_OFS = 8'h04;
   localparam logic [7:0] HOST_TXDATA_OFS = 8'h08;
   localparam logic [7:0] HOST_IRQ_STATUS_OFS = 8'h0C;
   localparam logic [7:0] HOST_IRQ_MASK_OFS = 8'h10;
   localparam logic [7:0] HOST_BYTE_COUNT_OFS = 8'h14;

   // Fields of the host control register
   localparam int CTRL_START_POS = 0;
   localparam int CTRL_STOP_POS = 1;
   localparam int CTRL_LIN_POS = 2;
   localparam int CTRL_LEGACY_POS = 3;
   localparam int CTRL_PARITY_POS = 4;

   // Interrupt events
   localparam int IRQ_N = 3;
   localparam int IRQ_TX_DONE_POS = 0;
   localparam int IRQ_STOPPED_POS = 1;
   localparam int IRQ_OVERRUN_POS = 2;
   localparam logic [IRQ_N-1:0] IRQ_MASK_RESET = 3'h0;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_PWR_ON = 4'h1,
      ST_ENABLE = 4'h2,
      ST_BRK_CFG = 4'h3,
      ST_RUN = 4'h4,
      ST_RD_REQ = 4'h5,
      ST_RD_GAP = 4'h6,
      ST_RD_EVAL = 4'h7,
      ST_SEND = 4'h8,
      ST_DIS_TXRX = 4'h9,
      ST_PWR_OFF = 4'hA
   } host_state_e;
endpackage : uart_host_pkg

// >>> core/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter and rising-edge pulse
// Assumes: Input is asynchronous to clk_i
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
module pin_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Pin side
   input wire logic pin_i,
   // Clean outputs
   output logic level_o,
   output logic rise_o
);
   logic s1;
   logic s2;
   logic s3;
   wire agree = (s2 == s3);

   // Change is taken only once the last two stages agree
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         level_o <= 1'b0;
         rise_o <= 1'b0;
      end else begin
         s1 <= pin_i;
         s2 <= s1;
         s3 <= s2;
         if (agree) begin
            level_o <= s3;
         end
         rise_o <= agree & s3 & ~level_o;
      end
   end
endmodule : pin_sync

// >>> core/irq_block.sv
// Purpose: Sticky interrupt status, mask and one level interrupt output
// Assumes: Status bits are cleared by writing ones
// Notes: A set in the same cycle as its clear wins, so no event is lost
`timescale 1ns/10ps
module irq_block #(
   parameter int N = 3
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Events and software access
   input wire logic [N-1:0] event_i,
   input wire logic status_wr_i,
   input wire logic mask_wr_i,
   input wire logic [N-1:0] wdata_i,
   // Register view and interrupt
   output logic [N-1:0] status_o,
   output logic [N-1:0] mask_o,
   output logic irq_o
);
   wire [N-1:0] clear = status_wr_i ? wdata_i : '0;
   wire [N-1:0] next_status = (status_o & ~clear) | event_i;

   // Status, mask and registered interrupt level
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_o <= '0;
         mask_o <= '0;
         irq_o <= 1'b0;
      end else begin
         status_o <= next_status;
         if (mask_wr_i) begin
            mask_o <= wdata_i;
         end
         irq_o <= |(next_status & (mask_wr_i ? wdata_i : mask_o));
      end
   end
endmodule : irq_block

// >>> core/uart_tx_host.sv
// Purpose: Host controller that sequences and feeds an asynchronous serial unit
// Assumes: Device port has one-cycle read latency; completion interrupt is a pin
// Notes: Software queues one byte at a time through the host data register
//
// Overview of operation
// - Stopping clears transmit and receive enables first, then unit power.
// - Starting sets unit power first, then transmit and receive enables.
// - In LIN mode the parity field is always written as no parity.
// - In continuous mode only the buffer-full flag decides readiness.
// - In LIN mode no second byte is queued while one is in flight.
// - In LIN mode a byte is written only when the status register reads zero.
// - In continuous mode each further byte waits for buffer-full to read 0.
// - Shutdown waits for every completion and then for shift-active 0.
// - Overrun is detected from a second unserved completion or by counting bytes against the shift-active flag.
// - Legacy mode writes break trigger 0 and break length 1, 0, 1.
`timescale 1ns/10ps
module uart_tx_host
   import uart_host_pkg::*;
#(
   parameter logic [2:0] BREAK_LENGTH_DEFAULT = 3'h5
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Host register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   output logic irq_o,
   // Device register port
   output logic [7:0] dev_addr_o,
   output logic [DEV_W-1:0] dev_wdata_o,
   output logic dev_we_o,
   output logic dev_re_o,
   input wire logic [DEV_W-1:0] dev_rdata_i,
   // Device completion interrupt pin
   input wire logic transmit_complete_interrupt_i
);
   host_state_e state;
   host_state_e next_state;
   logic lin_mode;
   logic legacy_mode;
   logic [1:0] parity_sel;
   logic start_req;
   logic stop_req;
   logic running;
   logic draining;
   logic [DEV_W-1:0] tx_byte;
   logic tx_pending;
   logic [1:0] dev_flags;
   logic [CNT_W-1:0] outstanding;
   logic [CNT_W-1:0] byte_count;
   logic done_unserved;
   logic [IRQ_N-1:0] irq_status;
   logic [IRQ_N-1:0] irq_mask;

   logic done_level;
   logic done_pulse;

   // Completion pin comes from the device's clock domain
   pin_sync u_done_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .pin_i(transmit_complete_interrupt_i),
      .level_o(done_level),
      .rise_o(done_pulse)
   );

   // Host register decode
   wire sel_ctrl = (addr_i == HOST_CTRL_OFS);
   wire sel_status = (addr_i == HOST_STATUS_OFS);
   wire sel_txdata = (addr_i == HOST_TXDATA_OFS);
   wire sel_irq_st = (addr_i == HOST_IRQ_STATUS_OFS);
   wire sel_irq_mask = (addr_i == HOST_IRQ_MASK_OFS);
   wire sel_count = (addr_i == HOST_BYTE_COUNT_OFS);
   wire wr_ctrl = wr_i & sel_ctrl;
   wire wr_txdata = wr_i & sel_txdata;

   // Effective parity: forced to none on a LIN bus
   wire [1:0] parity_eff = lin_mode ? PARITY_NONE : parity_sel;

   // Device status flags as read back
   wire rd_buf_full = dev_rdata_i[TX_BUFFER_FULL_FLAG_POS];
   wire rd_shift = dev_rdata_i[TX_SHIFT_ACTIVE_FLAG_POS];
   // Continuous mode looks only at buffer-full, since the pair passes through 11
   wire ready_cont = ~rd_buf_full;
   // LIN mode needs the whole status register at zero and nothing in flight
   wire ready_lin = (dev_rdata_i == '0) && (outstanding == '0);
   wire send_ok = lin_mode ? ready_lin : ready_cont;
   wire drain_done = ~rd_shift;

   // Overrun: a second completion before the first was served, or the
   // shifter is idle while more than one byte is still counted in flight
   wire overrun_served = done_pulse & done_unserved;
   wire overrun_count = (state == ST_RD_EVAL) & ~rd_shift & ~rd_buf_full &
                        (outstanding > {{(CNT_W-1){1'b0}}, 1'b1});
   wire ev_overrun = overrun_served | overrun_count;
   wire ev_stopped = (state == ST_PWR_OFF);
   wire [IRQ_N-1:0] irq_events = {ev_overrun, ev_stopped, done_pulse};

   irq_block #(
      .N(IRQ_N)
   ) u_irq (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .event_i(irq_events),
      .status_wr_i(wr_i & sel_irq_st),
      .mask_wr_i(wr_i & sel_irq_mask),
      .wdata_i(wdata_i[IRQ_N-1:0]),
      .status_o(irq_status),
      .mask_o(irq_mask),
      .irq_o(irq_o)
   );

   // Sequencer next state
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (start_req) begin
               next_state = ST_PWR_ON;
            end
         end
         ST_PWR_ON: next_state = ST_ENABLE;
         ST_ENABLE: next_state = ST_BRK_CFG;
         ST_BRK_CFG: next_state = ST_RUN;
         ST_RUN: begin
            // A byte taken before the stop still goes out, so stop cannot hang on it
            if (tx_pending) begin
               next_state = ST_RD_REQ;
            end else if (stop_req && outstanding == '0) begin
               next_state = ST_RD_REQ;
            end
         end
         ST_RD_REQ: next_state = ST_RD_GAP;
         ST_RD_GAP: next_state = ST_RD_EVAL;
         ST_RD_EVAL: begin
            if (draining) begin
               next_state = drain_done ? ST_DIS_TXRX : ST_RD_REQ;
            end else begin
               next_state = send_ok ? ST_SEND : ST_RUN;
            end
         end
         ST_SEND: next_state = ST_RUN;
         ST_DIS_TXRX: next_state = ST_PWR_OFF;
         ST_PWR_OFF: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // Device port values, registered on the way out
   logic [7:0] next_dev_addr;
   logic [DEV_W-1:0] next_dev_wdata;
   logic next_dev_we;
   logic next_dev_re;
   always_comb begin
      next_dev_addr = DEV_SERIAL_MODE_OFS;
      next_dev_wdata = '0;
      next_dev_we = 1'b0;
      next_dev_re = 1'b0;
      unique case (state)
         ST_PWR_ON: begin
            next_dev_we = 1'b1;
            next_dev_wdata[UNIT_POWER_ENABLE_POS] = 1'b1;
            next_dev_wdata[PARITY_SELECT_LOW_POS +: 2] = parity_eff;
         end
         ST_ENABLE: begin
            next_dev_we = 1'b1;
            next_dev_wdata[UNIT_POWER_ENABLE_POS] = 1'b1;
            next_dev_wdata[TRANSMIT_ENABLE_BIT_POS] = 1'b1;
            next_dev_wdata[RECEIVE_ENABLE_BIT_POS] = 1'b1;
            next_dev_wdata[PARITY_SELECT_LOW_POS +: 2] = parity_eff;
         end
         ST_BRK_CFG: begin
            // Trigger is written 0 and never read back, as it reads as 0 anyway
            next_dev_we = 1'b1;
            next_dev_addr = DEV_BREAK_CTL_OFS;
            next_dev_wdata[BREAK_TRANSMIT_TRIGGER_POS] = 1'b0;
            next_dev_wdata[BREAK_LENGTH_LOW_POS +: 3] =
               legacy_mode ? BREAK_LENGTH_LEGACY : BREAK_LENGTH_DEFAULT;
         end
         ST_RD_REQ: begin
            next_dev_re = 1'b1;
            next_dev_addr = DEV_TX_STATUS_OFS;
         end
         ST_SEND: begin
            next_dev_we = 1'b1;
            next_dev_addr = DEV_TX_BUFFER_OFS;
            next_dev_wdata = tx_byte;
         end
         ST_DIS_TXRX: begin
            // Power stays on while the enables drop
            next_dev_we = 1'b1;
            next_dev_wdata[UNIT_POWER_ENABLE_POS] = 1'b1;
            next_dev_wdata[PARITY_SELECT_LOW_POS +: 2] = parity_eff;
         end
         ST_PWR_OFF: begin
            next_dev_we = 1'b1;
         end
         default: begin
            next_dev_we = 1'b0;
         end
      endcase
   end

   // Host read mux
   wire [DATA_W-1:0] status_word = {{(DATA_W-16){1'b0}}, outstanding,
                                    3'h0, (state != ST_IDLE), dev_flags,
                                    tx_pending, running};
   wire [DATA_W-1:0] ctrl_word = {{(DATA_W-6){1'b0}}, parity_sel, legacy_mode,
                                  lin_mode, 2'h0};
   wire [DATA_W-1:0] next_rdata =
      sel_ctrl ? ctrl_word :
      sel_status ? status_word :
      sel_txdata ? {{(DATA_W-DEV_W){1'b0}}, tx_byte} :
      sel_irq_st ? {{(DATA_W-IRQ_N){1'b0}}, irq_status} :
      sel_irq_mask ? {{(DATA_W-IRQ_N){1'b0}}, irq_mask} :
      sel_count ? {{(DATA_W-CNT_W){1'b0}}, byte_count} : '0;

   // Byte bookkeeping: one in flight per send, one less per completion
   wire sent = (state == ST_SEND);
   wire dec_ok = done_pulse & (outstanding != '0);
   wire [CNT_W-1:0] next_outstanding = outstanding + CNT_W'(sent) - CNT_W'(dec_ok);

   // State and device port registers
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= ST_IDLE;
         dev_addr_o <= '0;
         dev_wdata_o <= '0;
         dev_we_o <= 1'b0;
         dev_re_o <= 1'b0;
         rdata_o <= '0;
      end else begin
         state <= next_state;
         dev_addr_o <= next_dev_addr;
         dev_wdata_o <= next_dev_wdata;
         dev_we_o <= next_dev_we;
         dev_re_o <= next_dev_re;
         rdata_o <= rd_i ? next_rdata : '0;
      end
   end

   // Control fields; start and stop are held requests until acted on
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lin_mode <= 1'b0;
         legacy_mode <= 1'b0;
         parity_sel <= PARITY_NONE;
         start_req <= 1'b0;
         stop_req <= 1'b0;
      end else begin
         if (wr_ctrl && state == ST_IDLE) begin
            lin_mode <= wdata_i[CTRL_LIN_POS];
            legacy_mode <= wdata_i[CTRL_LEGACY_POS];
            parity_sel <= wdata_i[CTRL_PARITY_POS +: 2];
         end
         start_req <= (wr_ctrl & wdata_i[CTRL_START_POS] & (state == ST_IDLE)) |
                      (start_req & (state != ST_IDLE));
         stop_req <= (wr_ctrl & wdata_i[CTRL_STOP_POS] & running) |
                     (stop_req & (state != ST_PWR_OFF));
      end
   end

   // Transmit data, flags and counters
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_byte <= '0;
         tx_pending <= 1'b0;
         running <= 1'b0;
         draining <= 1'b0;
         dev_flags <= 2'h0;
         outstanding <= '0;
         byte_count <= '0;
         done_unserved <= 1'b0;
      end else begin
         // A byte written while one waits is refused, never overwriting it
         if (wr_txdata && !tx_pending) begin
            tx_byte <= wdata_i[DEV_W-1:0];
         end
         tx_pending <= (wr_txdata & running & ~stop_req) | (tx_pending & ~sent);
         running <= (state == ST_BRK_CFG) | (running & (state != ST_PWR_OFF));
         draining <= (state == ST_RUN && next_state == ST_RD_REQ) ?
                     (stop_req & ~tx_pending) : draining;
         if (state == ST_RD_EVAL) begin
            dev_flags <= {rd_buf_full, rd_shift};
         end
         outstanding <= next_outstanding;
         byte_count <= byte_count + CNT_W'(sent);
         // A status poll serves the latest completion
         done_unserved <= done_pulse | (done_unserved & (state != ST_RD_EVAL));
      end
   end
endmodule : uart_tx_host

// >>> bench/dev_model.sv
// Purpose: Behavioural serial unit behind the host controller's device port
// Assumes: One-cycle read latency; frame length in clock cycles set by the bench
// Notes: Counters expose misuse so the bench can judge the controller
`timescale 1ns/10ps
module dev_model
   import uart_host_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Device port
   input wire logic [7:0] dev_addr_i,
   input wire logic [DEV_W-1:0] dev_wdata_i,
   input wire logic dev_we_i,
   input wire logic dev_re_i,
   output logic [DEV_W-1:0] dev_rdata_o,
   output logic complete_o,
   // Bench control and view
   input wire logic [7:0] frame_i,
   input wire logic mute_i,
   output logic [7:0] mode_o,
   output logic [7:0] brk_o,
   output logic [7:0] sent_o,
   output logic [7:0] last_o,
   output logic [7:0] bad_o,
   output logic [7:0] busy_o
);
   logic full, shift, buf_wr, mode_wr;
   logic [7:0] buf_q, shreg, timer;
   logic [2:0] pulse;

   // Port decode
   assign buf_wr = dev_we_i && dev_addr_i == DEV_TX_BUFFER_OFS;
   assign mode_wr = dev_we_i && dev_addr_i == DEV_SERIAL_MODE_OFS;
   assign complete_o = pulse != 3'h0;

   // Registers and shifter; read data toggles outside its valid cycle, so stale data fails
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {full, shift, buf_q, shreg, timer, pulse} <= '0;
         {dev_rdata_o, mode_o, brk_o, sent_o, last_o, bad_o, busy_o} <= '0;
      end else begin
         dev_rdata_o <= ~dev_rdata_o;
         if (dev_re_i && dev_addr_i == DEV_TX_STATUS_OFS) dev_rdata_o <= {6'h00, full, shift};
         if (dev_re_i && dev_addr_i == DEV_BREAK_CTL_OFS) dev_rdata_o <= brk_o;
         if (mode_wr) mode_o <= dev_wdata_i;
         if (mode_wr && shift && !dev_wdata_i[6]) bad_o <= bad_o + 8'h01;
         // Trigger is never stored, so it reads 0 and counts as already cleared
         if (dev_we_i && dev_addr_i == DEV_BREAK_CTL_OFS) brk_o <= dev_wdata_i & 8'hDF;
         if (pulse != 3'h0) pulse <= pulse - 3'h1;
         if (mode_o[7] && mode_o[6] && full && !shift) begin
            shift <= 1'b1;
            full <= 1'b0;
            shreg <= buf_q;
            timer <= frame_i;
         end else if (shift) begin
            timer <= timer - 8'h01;
         end
         // Frame end: report it, then a waiting byte moves in (11 to 01)
         if (shift && timer == 8'h01) begin
            sent_o <= sent_o + 8'h01;
            last_o <= shreg;
            pulse <= mute_i ? 3'h0 : 3'h4;
            shift <= full;
            full <= 1'b0;
            shreg <= buf_q;
            timer <= frame_i;
         end
         if (buf_wr) begin
            full <= 1'b1;
            buf_q <= full ? buf_q ^ dev_wdata_i : dev_wdata_i;
            bad_o <= bad_o + {7'h00, full};
            busy_o <= busy_o + {7'h00, full | shift};
         end
      end
   end
endmodule : dev_model

// >>> bench/uart_tx_host_checker.sv
// Purpose: Port-level checks of the serial-unit host controller
// Assumes: Sees only the controller's ports
// Notes: Helper flops hold the last device status read and mode written
`timescale 1ns/10ps
module uart_tx_host_checker
   import uart_host_pkg::*;
#(
   parameter logic [2:0] BREAK_LENGTH_DEFAULT = 3'h5
) (
   // Clock, reset and host port
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic irq_o,
   // Device port
   input wire logic [7:0] dev_addr_o,
   input wire logic [DEV_W-1:0] dev_wdata_o,
   input wire logic dev_we_o,
   input wire logic dev_re_o,
   input wire logic [DEV_W-1:0] dev_rdata_i,
   input wire logic transmit_complete_interrupt_i
);
   logic st_rd, lin, mode_wr, buf_wr;
   logic [1:0] st;
   logic [7:0] mode;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   // Device write decode
   assign mode_wr = dev_we_o && dev_addr_o == DEV_SERIAL_MODE_OFS;
   assign buf_wr = dev_we_o && dev_addr_o == DEV_TX_BUFFER_OFS;

   // LIN mode is taken with each start request, as the controller is idle then
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {st_rd, lin, st, mode} <= '0;
      end else begin
         st_rd <= dev_re_o && dev_addr_o == DEV_TX_STATUS_OFS;
         if (st_rd) st <= dev_rdata_i[1:0];
         if (mode_wr) mode <= dev_wdata_o;
         if (wr_i && addr_i == HOST_CTRL_OFS && wdata_i[0]) lin <= wdata_i[2];
      end
   end

   chk_power_first: assert property (mode_wr && dev_wdata_o[6] |-> mode[7])
      else $error("enable written before unit power");
   chk_enables_off: assert property (mode_wr && !dev_wdata_o[7] |->
      dev_wdata_o[6:5] == 2'h0 && mode[6:5] == 2'h0)
      else $error("power cleared before enables");
   chk_full_clear: assert property (buf_wr |-> !st[1])
      else $error("buffer written while full");
   chk_shift_idle: assert property (mode_wr && mode[6] && !dev_wdata_o[6] |-> !st[0])
      else $error("transmitter disabled while shifting");
   chk_break_trigger: assert property (dev_we_o && dev_addr_o == DEV_BREAK_CTL_OFS |->
      !dev_wdata_o[5])
      else $error("break trigger written as one");
   chk_lin_parity: assert property (mode_wr && lin |-> dev_wdata_o[4:3] == PARITY_NONE)
      else $error("parity used on LIN");
   chk_lin_status: assert property (buf_wr && lin |-> st == 2'h0)
      else $error("LIN byte queued while busy");
   chk_read_idle: assert property (!rd_i |=> rdata_o == '0)
      else $error("read data outside its cycle");

   cover property (st_rd && dev_rdata_i[1:0] == 2'h3);
   cover property (irq_o);
   cover property (mode_wr && !dev_wdata_o[7]);
endmodule : uart_tx_host_checker

bind uart_tx_host uart_tx_host_checker #(.BREAK_LENGTH_DEFAULT(BREAK_LENGTH_DEFAULT)) i_chk (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .dev_addr_o(dev_addr_o),
   .dev_wdata_o(dev_wdata_o), .dev_we_o(dev_we_o), .dev_re_o(dev_re_o),
   .dev_rdata_i(dev_rdata_i), .transmit_complete_interrupt_i(transmit_complete_interrupt_i));

// >>> bench/tb.sv
// Purpose: Self-checking bench for the serial-unit host controller
// Assumes: Frames of 40 cycles; break length default set to 2 to tell legacy apart
// Notes: Table rows cover register resets; sequences follow as hand tests
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
   $display("unexpected %0t: got %h want %h", $time, a, b); end end
module tb
   import uart_host_pkg::*;
;
   typedef struct {logic [7:0] a; logic w; logic [31:0] d;} row_s;
   logic clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, mute = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0, rdata_o, d;
   logic irq_o, dev_we, dev_re, done;
   logic [7:0] dev_addr, dev_wdata, dev_rdata, mode, brk, sent, last, bad, busy, b0;
   int fails = 0, samples_checked = 0;
   row_s rows[9] = '{'{HOST_STATUS_OFS, 1'h0, 32'h0}, '{HOST_IRQ_MASK_OFS, 1'h0, 32'h0},
      '{HOST_BYTE_COUNT_OFS, 1'h0, 32'h0}, '{HOST_IRQ_STATUS_OFS, 1'h0, 32'h0},
      '{HOST_CTRL_OFS, 1'h0, 32'h0}, '{HOST_IRQ_MASK_OFS, 1'h1, 32'h7},
      '{HOST_IRQ_MASK_OFS, 1'h0, 32'h7}, '{8'h18, 1'h1, 32'hFF}, '{8'h18, 1'h0, 32'h0}};

   always #25 clk_i = ~clk_i;

   uart_tx_host #(.BREAK_LENGTH_DEFAULT(3'h2)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .irq_o(irq_o), .dev_addr_o(dev_addr), .dev_wdata_o(dev_wdata), .dev_we_o(dev_we),
      .dev_re_o(dev_re), .dev_rdata_i(dev_rdata), .transmit_complete_interrupt_i(done));
   dev_model i_dev (.clk_i(clk_i), .rst_b_i(rst_b_i), .dev_addr_i(dev_addr),
      .dev_wdata_i(dev_wdata), .dev_we_i(dev_we), .dev_re_i(dev_re), .dev_rdata_o(dev_rdata),
      .complete_o(done), .frame_i(8'h28), .mute_i(mute), .mode_o(mode), .brk_o(brk),
      .sent_o(sent), .last_o(last), .bad_o(bad), .busy_o(busy));

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
   endtask : rd

   // Bounded status poll, so a stuck design shows as a mismatch
   task automatic poll(input logic [31:0] m, input logic [31:0] v);
      int n = 0;
      do begin
         rd(HOST_STATUS_OFS);
         n++;
      end while ((d & m) !== v && n < 500);
      `CHK(d & m, v)
   endtask : poll

   task automatic send(input logic [7:0] b);
      wr(HOST_TXDATA_OFS, {24'h000000, b});
      poll(32'h2, 32'h0);
   endtask : send

   task automatic wait_sent(input logic [7:0] v);
      int n = 0;
      while (sent !== v && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      `CHK(sent, v)
   endtask : wait_sent

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   // Watchdog: the whole sequence needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      stop_test;
   end

   initial begin
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         else begin
            rd(rows[i].a);
            `CHK(d, rows[i].d)
         end
      end
      $display("test registers done");
      // Start, three bytes back to back, stop while still shifting
      wr(HOST_CTRL_OFS, 32'h1);
      poll(32'h1, 32'h1);
      `CHK(mode, 8'hE0)
      `CHK(brk, 8'h08)
      for (int i = 0; i < 3; i++) send(8'hA5 + 8'(i));
      wr(HOST_CTRL_OFS, 32'h2);
      poll(32'h1, 32'h0);
      `CHK(sent, 8'h03)
      `CHK(last, 8'hA7)
      `CHK(bad, 8'h00)
      `CHK(mode, 8'h00)
      rd(HOST_IRQ_STATUS_OFS);
      `CHK(d[1:0], 2'h3)
      `CHK(irq_o, 1'b1)
      rd(HOST_BYTE_COUNT_OFS);
      `CHK(d, 32'h3)
      wr(HOST_IRQ_STATUS_OFS, 32'h7);
      rd(HOST_IRQ_STATUS_OFS);
      `CHK(d, 32'h0)
      `CHK(irq_o, 1'b0)
      $display("test continuous done");
      // LIN with parity asked for; only the stop event is unmasked
      wr(HOST_IRQ_MASK_OFS, 32'h2);
      wr(HOST_CTRL_OFS, 32'h35);
      poll(32'h1, 32'h1);
      `CHK(mode[4:3], 2'h0)
      b0 = busy;
      send(8'h3C);
      send(8'hC3);
      wait_sent(8'h05);
      `CHK(busy, b0)
      `CHK(last, 8'hC3)
      rd(HOST_IRQ_STATUS_OFS);
      `CHK(d[0], 1'b1)
      `CHK(irq_o, 1'b0)
      wr(HOST_CTRL_OFS, 32'h2);
      poll(32'h1, 32'h0);
      `CHK(irq_o, 1'b1)
      wr(HOST_IRQ_STATUS_OFS, 32'h7);
      $display("test lin done");
      // Legacy break settings; parity asked for off LIN must reach the device
      wr(HOST_CTRL_OFS, 32'h29);
      poll(32'h1, 32'h1);
      `CHK(brk, 8'h14)
      `CHK(mode[4:3], 2'h2)
      wr(HOST_CTRL_OFS, 32'h2);
      poll(32'h1, 32'h0);
      $display("test legacy done");
      // Completions lost: the next poll sees an idle unit with bytes outstanding
      wr(HOST_CTRL_OFS, 32'h1);
      poll(32'h1, 32'h1);
      mute <= 1'b1;
      send(8'h11);
      send(8'h22);
      wait_sent(8'h07);
      send(8'h33);
      rd(HOST_IRQ_STATUS_OFS);
      `CHK(d[2], 1'b1)
      $display("test overrun done");
      stop_test;
   end
endmodule : tb
